// ---- pkg/cpf_cfg.svh ----
// Constants for the packet former: register map, fields, reset values, packet codes.
// Function
// - Frame-valid and line-valid polarity set separately for every receive port.
// - Raw frame valid only after frame-valid held a programmable link-clock count, default 128.
// - Setup violated: first video line of the frame dropped by default; kept if line-valid rises in the same link cycle as frame-valid.
// - Optional control forwards that first line instead, even with missing pixels.
// - No minimum time between last line and frame-valid going away.
// - Payload bytes carried unchanged as 8-bit words whatever their content.
// - Short 32-bit sync packets use data types 0x00 to 0x0F.
// - Long packet: 32-bit header, payload bytes, 16-bit footer.
// - Header holds identifier byte, 16-bit word count, then ECC byte.
// - ECC covers identifier and word count; corrects one, detects two bit errors.
// - Word count equals number of payload bytes.
// - Footer is 16-bit CRC over the payload bytes.
// - Identifier: channel in top two bits, data type in low six.
// - Ports fed with packet input pass received data type through unchanged.
// - Raw ports use per-port identifier setting, one for 10-bit, one for 12-bit.
// - Raw identifier bits 7:6 give channel, bits 5:0 give data type.
// - Output multiplexes interleaved streams on up to four two-bit channels.
// - Per-port table maps each incoming channel to any of four output channels.
// - All sources leave as one stream, told apart only by channel.
// - Packet read from a line buffer only once wholly present there.
`ifndef CPF_CFG_SVH
`define CPF_CFG_SVH

`define CPF_PORTS           4
`define CPF_BUF_DEPTH       128
`define CPF_BUF_LAST        8'h7F
`define CPF_SETUP_SAT       9'h100

// ******************************
// Register offsets
// ******************************
`define CPF_OFS_RAW10_STREAM_IDENTIFIER    8'h70
`define CPF_OFS_RAW12_STREAM_IDENTIFIER    8'h71
`define CPF_OFS_POLARITY    8'h7C
`define CPF_OFS_MIN_SETUP   8'hBC
`define CPF_OFS_VCMAP       8'hD0
`define CPF_OFS_MODE        8'hD1
`define CPF_OFS_PORT_SEL    8'hF0
`define CPF_OFS_STATUS      8'hF1

// ******************************
// Reset values and fields
// ******************************
`define CPF_RST_RAW10_STREAM_IDENTIFIER    8'h2B
`define CPF_RST_RAW12_STREAM_IDENTIFIER    8'h2C
`define CPF_RST_POLARITY    8'h00
`define CPF_RST_MIN_SETUP   8'h80
`define CPF_RST_VCMAP       8'hE4
`define CPF_RST_MODE        8'h00
`define CPF_POL_FV_BIT      0
`define CPF_POL_LV_BIT      1
`define CPF_MODE_RAW_BIT    0
`define CPF_MODE_RAW12_BIT  1
`define CPF_MODE_FWD_BIT    2
`define CPF_MODE_LSYNC_BIT  3

// ******************************
// Packet codes and checksums
// ******************************
`define CPF_DT_FS           6'h00
`define CPF_DT_FE           6'h01
`define CPF_DT_LS           6'h02
`define CPF_DT_LE           6'h03
`define CPF_ECC_M0          24'hF1_2CB7
`define CPF_ECC_M1          24'hF2_555B
`define CPF_ECC_M2          24'h74_9A6D
`define CPF_ECC_M3          24'hB8_E38E
`define CPF_ECC_M4          24'hDF_03F0
`define CPF_ECC_M5          24'hEF_FC00
`define CPF_CRC_POLY        16'h8408
`define CPF_CRC_SEED        16'hFFFF

`endif

// ---- pkg/cpf_pkg.sv ----
// Types shared by the packet former.
package cpf_pkg;
    typedef enum logic [3:0] {
        CPF_IDLE, CPF_FS, CPF_LS, CPF_HDR, CPF_PAY, CPF_CRC, CPF_LE, CPF_FE
    } cpf_tx_state_t;
endpackage

// ---- verification/cpf_csi_rx_model.sv ----
// Downstream receiver model that takes the packet byte stream.
module cpf_csi_rx_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       stall,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] got_q[$];
    // Ready toggles when stalling, so the hold path is exercised
    always @(posedge clk_sys) begin
        if (!rst_n) tx_ready <= 1'b0;
        else tx_ready <= stall ? !tx_ready : 1'b1;
        if (rst_n && tx_valid && tx_ready) got_q.push_back({tx_last, tx_data});
    end
endmodule

// ---- verification/cpf_packet_former_monitor.sv ----
// Port-level checker for the packet former, bound to its top module.
module cpf_monitor (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_last,
    input wire logic       tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    logic [7:0] cnt_reg;
    wire        take = tx_valid && tx_ready;
    // Bytes taken so far in the current packet
    always_ff @(posedge clk_sys) begin
        if (!rst_n || (take && tx_last)) cnt_reg <= 8'h00;
        else if (take) cnt_reg <= cnt_reg + 8'h01;
    end
    // Write then read of the setup minimum
    sequence s_wr_min;
        reg_wr && reg_addr == 8'hBC;
    endsequence
    sequence s_rd_min;
        reg_rd && reg_addr == 8'hBC;
    endsequence
    property p_min_rw;
        s_wr_min ##2 s_rd_min |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
    endproperty
    property p_gap;
        take && !tx_last |=> tx_valid;
    endproperty
    property p_fall;
        $fell(tx_valid) |-> $past(tx_ready);
    endproperty
    property p_rd_unm;
        reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00;
    endproperty
    property p_rd_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    property p_short;
        take && tx_last |-> cnt_reg >= 8'h03;
    endproperty
    property p_long;
        tx_valid |-> cnt_reg <= 8'h85;
    endproperty
    a_min_rw: assert property (p_min_rw) else $error("setup minimum readback wrong");
    a_hold: assert property (p_hold) else $error("byte changed while stalled");
    a_gap: assert property (p_gap) else $error("gap inside packet");
    a_fall: assert property (p_fall) else $error("byte withdrawn untaken");
    a_rd_unm: assert property (p_rd_unm) else $error("unmapped read not zero");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_short: assert property (p_short) else $error("packet too short");
    a_long: assert property (p_long) else $error("packet too long");
endmodule

bind cpf_packet_former cpf_monitor u_cpf_monitor (
    .clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .tx_valid, .tx_data, .tx_last, .tx_ready
);

// ---- verification/tb_csi2_packet_former_vc_map.sv ----
// Self-checking bench for the packet former.
`include "cpf_cfg.svh"
module tb_csi2_packet_former_vc_map;
    timeunit 1ns;
    timeprecision 1ps;
    logic            clk_sys = 0, clk_link = 0, rst_n = 0, stall = 0;
    logic            reg_wr = 0, reg_rd = 0, tx_valid, tx_last, tx_ready;
    logic [7:0]      reg_addr = '0, reg_wdata = '0, reg_rdata, tx_data;
    logic [3:0]      rx_frame_valid = '0, rx_line_valid = '0;
    logic [3:0][7:0] rx_data = '0;
    logic [3:0][1:0] rx_vc = '0;
    logic [3:0][5:0] rx_dt = '0;
    logic [8:0]      exp_q[$];
    int              n_mismatch = 0, num_checks = 0;
    initial forever #10 clk_sys = ~clk_sys;
    initial begin
        #3;
        forever #7.5 clk_link = ~clk_link;
    end
    cpf_packet_former u_cpf_packet_former (.clk_sys, .rst_n, .clk_link, .reg_addr, .reg_wr,
        .reg_wdata, .reg_rd, .reg_rdata, .rx_frame_valid, .rx_line_valid, .rx_data, .rx_vc,
        .rx_dt, .tx_valid, .tx_data, .tx_last, .tx_ready);
    cpf_csi_rx_model u_cpf_csi_rx_model (.clk_sys, .rst_n, .stall, .tx_valid, .tx_data,
        .tx_last, .tx_ready);
    // ********************************
    // Access, stimulus and compare tasks
    // ********************************
    task automatic chk(string what, logic [8:0] e, logic [8:0] g);
        num_checks++;
        if (e !== g) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        chk("reg_rdata", {1'b0, e}, {1'b0, reg_rdata});
    endtask
    // One frame: setup edges, then one line of n bytes counting up from b
    task automatic frame(int p, int setup, int n, logic [7:0] b, logic inv);
        @(posedge clk_link);
        rx_frame_valid[p] <= !inv;
        repeat (setup) @(posedge clk_link);
        for (int i = 0; i < n; i++) begin
            rx_line_valid[p] <= !inv;
            rx_data[p] <= b + 8'(i);
            @(posedge clk_link);
        end
        rx_line_valid[p] <= inv;
        repeat (3) @(posedge clk_link);
        rx_frame_valid[p] <= inv;
        @(posedge clk_sys);
    endtask
    function automatic logic [7:0] ecc(logic [23:0] d);
        logic [23:0] m[6] = '{`CPF_ECC_M0, `CPF_ECC_M1, `CPF_ECC_M2, `CPF_ECC_M3, `CPF_ECC_M4, `CPF_ECC_M5};
        ecc = 8'h00;
        for (int i = 0; i < 6; i++) ecc[i] = ^(d & m[i]);
    endfunction
    task automatic exp_pkt(logic [7:0] di, int n, logic [7:0] b, logic lng);
        logic [15:0] c = `CPF_CRC_SEED;
        logic [7:0]  x;
        exp_q.push_back({1'b0, di});
        exp_q.push_back({1'b0, 8'(n)});
        exp_q.push_back(9'h000);
        exp_q.push_back({!lng, ecc({16'(n), di})});
        for (int i = 0; i < n; i++) begin
            x = b + 8'(i);
            exp_q.push_back({1'b0, x});
            for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ x[k]) ? `CPF_CRC_POLY : 16'h0000);
        end
        if (lng) exp_q.push_back({1'b0, c[7:0]});
        if (lng) exp_q.push_back({1'b1, c[15:8]});
    endtask
    // Short packets carry a zero word count and no payload
    task automatic drain();
        int w = 0;
        while (u_cpf_csi_rx_model.got_q.size() < exp_q.size() && w < 3000) begin
            @(posedge clk_sys);
            w++;
        end
        repeat (40) @(posedge clk_sys);
        chk("byte count", 9'(exp_q.size()), 9'(u_cpf_csi_rx_model.got_q.size()));
        foreach (exp_q[i]) chk("tx byte", exp_q[i], u_cpf_csi_rx_model.got_q[i]);
        exp_q.delete();
        u_cpf_csi_rx_model.got_q.delete();
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #1_000_000;
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd(8'hBC, 8'h80);
        rd(8'h70, 8'h2B);
        rd(8'h71, 8'h2C);
        rd(8'h7C, 8'h00);
        rd(8'hD0, 8'hE4);
        rd(8'h00, 8'h00);
        wr(8'hBC, 8'h08);
        rd(8'hBC, 8'h08);
        wr(8'h70, 8'h6A);
        wr(8'h71, 8'hAC);
        wr(8'hD1, 8'h01);
        frame(0, 12, 5, 8'hA0, 1'b0);
        exp_pkt(8'h40, 0, 8'h00, 1'b0);
        exp_pkt(8'h6A, 5, 8'hA0, 1'b1);
        exp_pkt(8'h41, 0, 8'h00, 1'b0);
        drain();
        wr(8'hD1, 8'h03);
        frame(0, 2, 4, 8'h10, 1'b0);
        exp_pkt(8'h80, 0, 8'h00, 1'b0);
        exp_pkt(8'h81, 0, 8'h00, 1'b0);
        drain();
        wr(8'hD1, 8'h07);
        stall <= 1'b1;
        frame(0, 2, 4, 8'h10, 1'b0);
        exp_pkt(8'h80, 0, 8'h00, 1'b0);
        exp_pkt(8'hAC, 4, 8'h10, 1'b1);
        exp_pkt(8'h81, 0, 8'h00, 1'b0);
        drain();
        wr(8'hF0, 8'h02);
        wr(8'h7C, 8'h03);
        wr(8'hD1, 8'h01);
        rx_frame_valid[2] <= 1'b1;
        rx_line_valid[2] <= 1'b1;
        repeat (90) @(posedge clk_sys);
        u_cpf_csi_rx_model.got_q.delete();
        frame(2, 12, 3, 8'h55, 1'b1);
        exp_pkt(8'h00, 0, 8'h00, 1'b0);
        exp_pkt(8'h2B, 3, 8'h55, 1'b1);
        exp_pkt(8'h01, 0, 8'h00, 1'b0);
        drain();
        wr(8'hF0, 8'h03);
        wr(8'hD0, 8'hE7);
        wr(8'hD1, 8'h08);
        rx_dt[3] <= 6'h1E;
        frame(3, 12, 2, 8'hC0, 1'b0);
        exp_pkt(8'hC0, 0, 8'h00, 1'b0);
        exp_pkt(8'hC2, 0, 8'h00, 1'b0);
        exp_pkt(8'hDE, 2, 8'hC0, 1'b1);
        exp_pkt(8'hC3, 0, 8'h00, 1'b0);
        exp_pkt(8'hC1, 0, 8'h00, 1'b0);
        drain();
        final_report();
    end
endmodule

// ---- verilog/cpf_packet_former.sv ----
// Per-port raw/packet framing, channel remap and single multiplexed packet output.
`include "cpf_cfg.svh"

module cpf_packet_former
    import cpf_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   clk_link,
    input  wire logic [7:0]             reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    input  wire logic [3:0]             rx_frame_valid,
    input  wire logic [3:0]             rx_line_valid,
    input  wire logic [3:0][7:0]        rx_data,
    input  wire logic [3:0][1:0]        rx_vc,
    input  wire logic [3:0][5:0]        rx_dt,
    output logic                        tx_valid,
    output logic      [7:0]             tx_data,
    output logic                        tx_last,
    input  wire logic                   tx_ready
);

    // ******************************
    // Checksum functions
    // ******************************

    // Header ECC over {word count, identifier}, six parity bits, top two zero
    function automatic logic [7:0] cpf_ecc(input logic [23:0] d);
        cpf_ecc = {2'b00, ^(d & `CPF_ECC_M5), ^(d & `CPF_ECC_M4), ^(d & `CPF_ECC_M3),
                   ^(d & `CPF_ECC_M2), ^(d & `CPF_ECC_M1), ^(d & `CPF_ECC_M0)};
    endfunction

    // Reflected CRC-16, byte taken LSB first
    function automatic logic [15:0] cpf_crc(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ b[i]) ? ((r >> 1) ^ `CPF_CRC_POLY) : (r >> 1);
        end
        cpf_crc = r;
    endfunction

    // ******************************
    // Register file (system clock)
    // ******************************
    logic [7:0] raw10_stream_identifier_reg [0:3];
    logic [7:0] raw12_stream_identifier_reg [0:3];
    logic [7:0] polarity_reg [0:3];
    logic [7:0] vcmap_reg    [0:3];
    logic [7:0] mode_reg     [0:3];
    logic [7:0] min_setup_reg;
    logic [1:0] port_sel_reg;
    logic [7:0] rdata_reg;
    logic [3:0] pending;
    cpf_tx_state_t st_reg;

    // Address decode
    wire wr_raw10  = reg_wr && (reg_addr == `CPF_OFS_RAW10_STREAM_IDENTIFIER);
    wire wr_raw12  = reg_wr && (reg_addr == `CPF_OFS_RAW12_STREAM_IDENTIFIER);
    wire wr_pol    = reg_wr && (reg_addr == `CPF_OFS_POLARITY);
    wire wr_setup  = reg_wr && (reg_addr == `CPF_OFS_MIN_SETUP);
    wire wr_vcmap  = reg_wr && (reg_addr == `CPF_OFS_VCMAP);
    wire wr_mode   = reg_wr && (reg_addr == `CPF_OFS_MODE);
    wire wr_sel    = reg_wr && (reg_addr == `CPF_OFS_PORT_SEL);
    wire [7:0] status_val = {3'b000, (st_reg != CPF_IDLE), pending};

    // Read mux; unmapped offsets read zero
    wire [7:0] rd_mux =
        (reg_addr == `CPF_OFS_RAW10_STREAM_IDENTIFIER)  ? raw10_stream_identifier_reg[port_sel_reg] :
        (reg_addr == `CPF_OFS_RAW12_STREAM_IDENTIFIER)  ? raw12_stream_identifier_reg[port_sel_reg] :
        (reg_addr == `CPF_OFS_POLARITY)  ? polarity_reg[port_sel_reg] :
        (reg_addr == `CPF_OFS_MIN_SETUP) ? min_setup_reg :
        (reg_addr == `CPF_OFS_VCMAP)     ? vcmap_reg[port_sel_reg] :
        (reg_addr == `CPF_OFS_MODE)      ? mode_reg[port_sel_reg] :
        (reg_addr == `CPF_OFS_PORT_SEL)  ? {6'h00, port_sel_reg} :
        (reg_addr == `CPF_OFS_STATUS)    ? status_val : 8'h00;

    // Per-port registers sit behind the port select, one page per port
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int p = 0; p < `CPF_PORTS; p++) begin
                raw10_stream_identifier_reg[p] <= `CPF_RST_RAW10_STREAM_IDENTIFIER;
                raw12_stream_identifier_reg[p] <= `CPF_RST_RAW12_STREAM_IDENTIFIER;
                polarity_reg[p] <= `CPF_RST_POLARITY;
                vcmap_reg[p]    <= `CPF_RST_VCMAP;
                mode_reg[p]     <= `CPF_RST_MODE;
            end
            min_setup_reg <= `CPF_RST_MIN_SETUP;
            port_sel_reg  <= 2'b00;
        end else begin
            if (wr_raw10) raw10_stream_identifier_reg[port_sel_reg] <= reg_wdata;
            if (wr_raw12) raw12_stream_identifier_reg[port_sel_reg] <= reg_wdata;
            if (wr_pol)   polarity_reg[port_sel_reg] <= reg_wdata;
            if (wr_vcmap) vcmap_reg[port_sel_reg]    <= reg_wdata;
            if (wr_mode)  mode_reg[port_sel_reg]     <= reg_wdata;
            if (wr_setup) min_setup_reg <= reg_wdata;
            if (wr_sel)   port_sel_reg  <= reg_wdata[1:0];
        end
    end

    // Read data registered, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_n) rdata_reg <= 8'h00;
        else if (reg_rd) rdata_reg <= rd_mux;
    end
    assign reg_rdata = rdata_reg;

    // ******************************
    // Link-domain reset and shared per-port state
    // ******************************
    logic link_rst_s1;
    logic link_rst_n;
    logic [7:0] line_buf [0:3][0:`CPF_BUF_DEPTH-1];
    logic [3:0] pub_tgl;
    logic [3:0] ack_tgl;
    logic [3:0] rec_fs;
    logic [3:0] rec_long;
    logic [3:0] rec_fe;
    logic [7:0] rec_di  [0:3];
    logic [7:0] rec_len [0:3];

    // System reset is asynchronous to the link clock, so it is synchronised
    always_ff @(posedge clk_link) begin
        link_rst_s1 <= rst_n;
        link_rst_n  <= link_rst_s1;
    end

    // ******************************
    // Link-side framing, one copy per receive port
    // ******************************
    for (genvar p = 0; p < `CPF_PORTS; p++) begin : g_port
        // Config crossing: quasi-static, software changes it only between frames
        wire [27:0] cfg_sys = {min_setup_reg,
                               mode_reg[p][`CPF_MODE_RAW12_BIT] ? raw12_stream_identifier_reg[p] : raw10_stream_identifier_reg[p],
                               vcmap_reg[p],
                               mode_reg[p][`CPF_MODE_FWD_BIT], mode_reg[p][`CPF_MODE_RAW_BIT],
                               polarity_reg[p][`CPF_POL_LV_BIT], polarity_reg[p][`CPF_POL_FV_BIT]};
        logic [27:0] cfg_s1;
        logic [27:0] cfg_s2;
        logic        ack_s1;
        logic        ack_s2;
        logic        fv_q;
        logic        lv_q;
        logic [8:0]  setup_cnt;
        logic        first_pend;
        logic        fs_owed;
        logic        line_act;
        logic        line_keep;
        logic        fe_pend;
        logic [7:0]  wptr;
        logic [7:0]  cur_di;

        always_ff @(posedge clk_link) begin
            cfg_s1 <= cfg_sys;
            cfg_s2 <= cfg_s1;
            ack_s1 <= ack_tgl[p];
            ack_s2 <= ack_s1;
        end

        wire [7:0] c_min   = cfg_s2[27:20];
        wire [7:0] c_rawid = cfg_s2[19:12];
        wire [7:0] c_vcmap = cfg_s2[11:4];
        wire       c_fwd   = cfg_s2[3];
        wire       c_raw   = cfg_s2[2];
        wire fv = rx_frame_valid[p] ^ cfg_s2[0];
        wire lv = rx_line_valid[p] ^ cfg_s2[1];

        // Edge detection and setup check
        wire fv_rise   = fv && !fv_q;
        wire fv_fall   = !fv && fv_q;
        wire lv_rise   = lv && !lv_q && fv;
        wire lv_fall   = !lv && line_act;
        wire slot_free = (pub_tgl[p] == ack_s2);
        wire setup_ok  = (setup_cnt >= {1'b0, c_min});
        // Lines starting while the buffer is still owned by the sender are lost
        wire keep_new  = slot_free && (!first_pend || setup_ok || c_fwd);
        wire pub_line  = lv_fall && line_keep;
        wire fe_req    = fv_fall || fe_pend;
        wire pub_fe    = fe_req && slot_free && !line_act && !pub_line;
        // Raw ports take the configured identifier, packet ports remap channel
        wire [1:0] map_vc = c_vcmap[2*rx_vc[p] +: 2];
        wire [7:0] new_di = c_raw ? c_rawid : {map_vc, rx_dt[p]};

        // Frame and line tracking
        always_ff @(posedge clk_link) begin
            if (!link_rst_n) begin
                fv_q       <= 1'b0;
                lv_q       <= 1'b0;
                setup_cnt  <= 9'h000;
                first_pend <= 1'b0;
                fs_owed    <= 1'b0;
                line_act   <= 1'b0;
                line_keep  <= 1'b0;
                fe_pend    <= 1'b0;
                cur_di     <= 8'h00;
            end else begin
                fv_q <= fv;
                lv_q <= lv;
                if (!fv) setup_cnt <= 9'h000;
                else if (setup_cnt != `CPF_SETUP_SAT) setup_cnt <= setup_cnt + 9'h001;
                if (fv_rise) first_pend <= 1'b1;
                else if (lv_rise) first_pend <= 1'b0;
                if (fv_rise) fs_owed <= 1'b1;
                else if (pub_line || pub_fe) fs_owed <= 1'b0;
                if (lv_rise) begin
                    line_act  <= 1'b1;
                    line_keep <= keep_new;
                    cur_di    <= new_di;
                end else if (lv_fall) begin
                    line_act  <= 1'b0;
                end
                fe_pend <= fe_req && !pub_fe;
            end
        end

        // Record handed to the system side; toggle marks it complete
        always_ff @(posedge clk_link) begin
            if (!link_rst_n) begin
                pub_tgl[p]  <= 1'b0;
                rec_fs[p]   <= 1'b0;
                rec_long[p] <= 1'b0;
                rec_fe[p]   <= 1'b0;
                rec_di[p]   <= 8'h00;
                rec_len[p]  <= 8'h00;
            end else if (pub_line || pub_fe) begin
                pub_tgl[p]  <= ~pub_tgl[p];
                rec_fs[p]   <= fs_owed;
                rec_long[p] <= pub_line;
                rec_fe[p]   <= pub_fe;
                rec_di[p]   <= cur_di;
                rec_len[p]  <= wptr;
            end
        end

        // Payload capture; a line longer than the buffer is cut at its depth
        always_ff @(posedge clk_link) begin
            if (!link_rst_n) begin
                wptr <= 8'h00;
            end else if (lv_rise) begin
                wptr <= 8'h00;
                if (keep_new) begin
                    line_buf[p][0] <= rx_data[p];
                    wptr <= 8'h01;
                end
            end else if (line_act && lv && line_keep && (wptr <= `CPF_BUF_LAST)) begin
                line_buf[p][wptr[6:0]] <= rx_data[p];
                wptr <= wptr + 8'h01;
            end
        end
    end

    // ******************************
    // System-side request sync and arbitration
    // ******************************
    logic [3:0] req_s1;
    logic [3:0] req_s2;
    logic [1:0] cur_reg;
    logic [1:0] rr_reg;

    always_ff @(posedge clk_sys) begin
        req_s1 <= pub_tgl;
        req_s2 <= req_s1;
    end
    assign pending = req_s2 ^ ack_tgl;

    // Round robin starting after the last served port, so no port starves
    function automatic logic [1:0] cpf_pick(input logic [3:0] pend, input logic [1:0] last);
        logic [1:0] sel;
        sel = last;
        for (int i = 4; i >= 1; i--) begin
            if (pend[2'(last + 2'(i))]) sel = 2'(last + 2'(i));
        end
        cpf_pick = sel;
    endfunction

    // ******************************
    // Packet sequencer
    // ******************************
    logic [7:0]  idx_reg;
    logic [15:0] crc_reg;
    logic        f_fs;
    logic        f_long;
    logic        f_fe;
    logic        f_ls;
    logic [7:0]  di_reg;
    logic [7:0]  len_reg;
    logic        out_valid_reg;
    logic [7:0]  out_data_reg;
    logic        out_last_reg;

    wire [1:0] pick  = cpf_pick(pending, rr_reg);
    wire       start = (st_reg == CPF_IDLE) && (pending != 4'h0);
    wire       load  = (st_reg != CPF_IDLE) && (!out_valid_reg || tx_ready);
    wire       short_st = (st_reg == CPF_FS) || (st_reg == CPF_LS) ||
                          (st_reg == CPF_LE) || (st_reg == CPF_FE);
    wire [5:0] sync_dt = (st_reg == CPF_FS) ? `CPF_DT_FS :
                         (st_reg == CPF_FE) ? `CPF_DT_FE :
                         (st_reg == CPF_LS) ? `CPF_DT_LS : `CPF_DT_LE;
    wire [7:0] sdi     = {di_reg[7:6], sync_dt};
    wire [7:0] hdr_ecc = cpf_ecc({8'h00, len_reg, di_reg});
    wire [7:0] sh_ecc  = cpf_ecc({16'h0000, sdi});
    wire [7:0] pay     = line_buf[cur_reg][idx_reg[6:0]];
    wire [15:0] crc_nx = cpf_crc(crc_reg, pay);

    // Byte of the current state: identifier, word count low/high, ECC
    wire [7:0] cur_byte =
        short_st              ? ((idx_reg == 8'h00) ? sdi : (idx_reg == 8'h03) ? sh_ecc : 8'h00) :
        (st_reg == CPF_HDR)   ? ((idx_reg == 8'h00) ? di_reg :
                                 (idx_reg == 8'h01) ? len_reg :
                                 (idx_reg == 8'h03) ? hdr_ecc : 8'h00) :
        (st_reg == CPF_PAY)   ? pay :
                                ((idx_reg == 8'h00) ? crc_reg[7:0] : crc_reg[15:8]);
    wire st_done = (short_st || (st_reg == CPF_HDR)) ? (idx_reg == 8'h03) :
                   (st_reg == CPF_PAY) ? (idx_reg == len_reg - 8'h01) : (idx_reg == 8'h01);
    wire pkt_end = st_done && (st_reg != CPF_HDR) && (st_reg != CPF_PAY);

    // Successor states, skipping parts the record does not need
    wire cpf_tx_state_t after_le  = f_fe ? CPF_FE : CPF_IDLE;
    wire cpf_tx_state_t after_crc = f_ls ? CPF_LE : after_le;
    wire cpf_tx_state_t after_hdr = (len_reg != 8'h00) ? CPF_PAY : CPF_CRC;
    wire cpf_tx_state_t after_fs  = f_long ? (f_ls ? CPF_LS : CPF_HDR) : after_le;
    wire cpf_tx_state_t first_st  = rec_fs[pick] ? CPF_FS :
                                    rec_long[pick] ? (mode_reg[pick][`CPF_MODE_LSYNC_BIT] ? CPF_LS : CPF_HDR) :
                                    CPF_FE;
    cpf_tx_state_t st_next;
    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            CPF_IDLE: st_next = start ? first_st : CPF_IDLE;
            CPF_FS:   st_next = after_fs;
            CPF_LS:   st_next = CPF_HDR;
            CPF_HDR:  st_next = after_hdr;
            CPF_PAY:  st_next = CPF_CRC;
            CPF_CRC:  st_next = after_crc;
            CPF_LE:   st_next = after_le;
            CPF_FE:   st_next = CPF_IDLE;
        endcase
    end

    // State, index and record latch; records are stable while unacknowledged
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg  <= CPF_IDLE;
            idx_reg <= 8'h00;
            cur_reg <= 2'b00;
            rr_reg  <= 2'b11;
            ack_tgl <= 4'h0;
            f_fs    <= 1'b0;
            f_long  <= 1'b0;
            f_fe    <= 1'b0;
            f_ls    <= 1'b0;
            di_reg  <= 8'h00;
            len_reg <= 8'h00;
        end else if (start) begin
            st_reg  <= st_next;
            idx_reg <= 8'h00;
            cur_reg <= pick;
            rr_reg  <= pick;
            f_fs    <= rec_fs[pick];
            f_long  <= rec_long[pick];
            f_fe    <= rec_fe[pick];
            f_ls    <= mode_reg[pick][`CPF_MODE_LSYNC_BIT];
            di_reg  <= rec_di[pick];
            len_reg <= rec_len[pick];
        end else if (load) begin
            idx_reg <= st_done ? 8'h00 : idx_reg + 8'h01;
            if (st_done) st_reg <= st_next;
            if (st_done && (st_next == CPF_IDLE)) ack_tgl[cur_reg] <= ~ack_tgl[cur_reg];
        end
    end

    // Payload CRC, seeded at the header
    always_ff @(posedge clk_sys) begin
        if (!rst_n) crc_reg <= `CPF_CRC_SEED;
        else if (load && (st_reg == CPF_HDR)) crc_reg <= `CPF_CRC_SEED;
        else if (load && (st_reg == CPF_PAY)) crc_reg <= crc_nx;
    end

    // Output byte stage: data from flops, held until taken
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            out_valid_reg <= 1'b0;
            out_data_reg  <= 8'h00;
            out_last_reg  <= 1'b0;
        end else if (load) begin
            out_valid_reg <= 1'b1;
            out_data_reg  <= cur_byte;
            out_last_reg  <= pkt_end;
        end else if (tx_ready) begin
            out_valid_reg <= 1'b0;
        end
    end

    assign tx_valid = out_valid_reg;
    assign tx_data  = out_data_reg;
    assign tx_last  = out_last_reg;

endmodule
